// ---- core/ctsr_map.vh ----
`ifndef CTSR_MAP_VH
`define CTSR_MAP_VH

// Register offsets on the plain register port
`define CTSR_ADDR_W 4
`define CTSR_REG_TRIG_SRC 4'h0
`define CTSR_REG_TRIG_MODE 4'h1
`define CTSR_REG_SYNC_EN 4'h2
`define CTSR_REG_LINE_OE 4'h3
`define CTSR_REG_LINE_VAL 4'h4
`define CTSR_REG_STAT_SEL 4'h5
`define CTSR_REG_STATUS 4'h6
`define CTSR_REG_TRIG_STATE 4'h7

// Trigger source select, one bit per input: 0 = trigger line, 1 = star line
`define CTSR_SRC_LINE 1'b0
`define CTSR_SRC_STAR 1'b1

// Qualification modes, two bits per input
`define CTSR_MODE_W 2
`define CTSR_MODE_HIGH 2'h0
`define CTSR_MODE_LOW 2'h1
`define CTSR_MODE_RISE 2'h2
`define CTSR_MODE_FALL 2'h3

// Sync enable field positions
`define CTSR_SYNC_A_LINE0 0
`define CTSR_SYNC_B_LINE1 1
`define CTSR_SYNC_C_LINE2 2
`define CTSR_SYNC_C_STAR 3

// Status selector
`define CTSR_SEL_W 2
`define CTSR_STAT_SLOT 2'h0
`define CTSR_STAT_CLOCK 2'h1
`define CTSR_STAT_VERSION 2'h2
`define CTSR_STAT_OE 2'h3

// Clock source codes
`define CTSR_CLK_BACKPLANE 1'b0
`define CTSR_CLK_ONBOARD 1'b1

// Bidirectional line group: 8 trigger lines plus the star line
`define CTSR_NUM_IO 9
`define CTSR_STAR_IO 8
// Output-enable mask spans discrete indices 33 to 48
`define CTSR_OE_MASK_W 16
`define CTSR_OE_FIRST_INDEX 33

`define CTSR_DATA_W 16
`define CTSR_ZERO16 16'h0000

`endif

// ---- core/ctsr_sync3.v ----
`timescale 1ns/1ps
`default_nettype none
// Three-stage input synchroniser; the change is taken once stages two and three agree
module ctsr_sync3 #(
	parameter W = 1
) (
	input wire clk,
	input wire rst_n,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] s1_r;
	reg [W-1:0] s2_r;
	reg [W-1:0] s3_r;
	genvar i;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= {W{1'b0}};
			s2_r <= {W{1'b0}};
			s3_r <= {W{1'b0}};
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					q[i] <= 1'b0;
				end else if (s2_r[i] == s3_r[i]) begin
					q[i] <= s3_r[i];
				end
			end
		end
	endgenerate
endmodule // ctsr_sync3
`default_nettype wire

// ---- core/ctsr_qual.v ----
`timescale 1ns/1ps
`default_nettype none
`include "ctsr_map.vh"
// Level or edge qualification of one synchronised trigger source
module ctsr_qual (
	input wire clk,
	input wire rst_n,
	input wire src,
	input wire [`CTSR_MODE_W-1:0] mode,
	output reg trig
);
	reg prev_r;
	reg trig_nxt;
	always @* begin
		case (mode)
			`CTSR_MODE_HIGH: trig_nxt = src;
			`CTSR_MODE_LOW: trig_nxt = ~src;
			`CTSR_MODE_RISE: trig_nxt = src & ~prev_r;
			`CTSR_MODE_FALL: trig_nxt = ~src & prev_r;
			default: trig_nxt = 1'b0;
		endcase
	end
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_r <= 1'b0;
			trig <= 1'b0;
		end else begin
			prev_r <= src;
			trig <= trig_nxt;
		end
	end
endmodule // ctsr_qual
`default_nettype wire

// ---- core/ctsr_router.v ----
// Operation
// - Trigger A comes from line 0 or star A, B from line 1 or star B, C from line 2 or star.
// - Each trigger input takes exactly one of its two candidate sources at a time.
// - Sync A goes to line 0, sync B to line 1, sync C to line 2 and/or the star line.
// - Each sync destination has its own enable, so sync C may drive line 2 and star together.
// - Each trigger input fires on high level, low level, rising or falling edge.
// - Level modes hold the trigger for as long as the source sits at the active level.
// - Edge modes give one pulse per chosen transition and nothing while steady.
// - A host selector returns slot address, clock source, engine version or enable mask.
// - Clock source status reads 0 for backplane clock and 1 for on-board oscillator.
// - The enable mask has one bit per discrete index 33 to 48 showing driver enable.
// - The version item is a constant.
// - In the timing slot the block acts as a plain peripheral and drives no timing functions.
// - The clock switch is sampled once after power-on and then held.
// - All bidirectional trigger lines come up tri-stated until software enables them.
// - With both cores driving one line, the most recently written value is driven.
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ctsr_map.vh"
module ctsr_router #(
	parameter [`CTSR_DATA_W-1:0] ENGINE_VERSION = 16'h0001, // Arbitrary value
	parameter NUM_IO = `CTSR_NUM_IO
) (
	input wire CLK,
	input wire RESETN,
	input wire [`CTSR_ADDR_W-1:0] ADDR,
	input wire [`CTSR_DATA_W-1:0] WDATA,
	input wire WR,
	input wire RD,
	output reg [`CTSR_DATA_W-1:0] RDATA,
	input wire [NUM_IO-1:0] LINE_IN,
	output reg [NUM_IO-1:0] LINE_OUT,
	output reg [NUM_IO-1:0] LINE_OE,
	input wire STAR_A_IN,
	input wire STAR_B_IN,
	input wire [4:0] SLOT_ADDR,
	input wire CLK_SEL_SWITCH,
	input wire SYNC_A,
	input wire SYNC_B,
	input wire SYNC_C,
	input wire CORE_A_WR,
	input wire CORE_B_WR,
	input wire [NUM_IO-1:0] CORE_A_OE,
	input wire [NUM_IO-1:0] CORE_B_OE,
	input wire [NUM_IO-1:0] CORE_A_VAL,
	input wire [NUM_IO-1:0] CORE_B_VAL,
	output reg TRIG_A,
	output reg TRIG_B,
	output reg TRIG_C,
	output reg CLOCK_SOURCE,
	output reg TIMING_DRIVE
);
	reg rst_s1_r;
	reg rst_n_r;
	wire rst_n;
	reg [2:0] trig_src_r;
	reg [3*`CTSR_MODE_W-1:0] trig_mode_r;
	reg [3:0] sync_en_r;
	reg [NUM_IO-1:0] sw_oe_r;
	reg [NUM_IO-1:0] sw_val_r;
	reg [NUM_IO-1:0] drv_oe_r;
	reg [NUM_IO-1:0] drv_val_r;
	reg [`CTSR_SEL_W-1:0] stat_sel_r;
	reg clk_sel_r;
	reg clk_sel_done_r;
	reg [`CTSR_DATA_W-1:0] rdata_nxt;
	reg [`CTSR_DATA_W-1:0] status_nxt;
	reg [NUM_IO-1:0] line_out_nxt;
	wire [NUM_IO-1:0] line_s;
	wire [1:0] star_s;
	wire [2:0] src_sel;
	wire [2:0] trig_q;
	wire [`CTSR_OE_MASK_W-1:0] oe_mask;

	// Reset released through two flops
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end
	assign rst_n = rst_n_r;

	ctsr_sync3 #(
		.W(NUM_IO)
	) u_sync_line (
		.clk(CLK),
		.rst_n(rst_n),
		.d(LINE_IN),
		.q(line_s)
	);

	ctsr_sync3 #(
		.W(2)
	) u_sync_star (
		.clk(CLK),
		.rst_n(rst_n),
		.d({STAR_B_IN, STAR_A_IN}),
		.q(star_s)
	);

	// One select bit per input makes the two sources exclusive by construction
	assign src_sel[0] = trig_src_r[0] ? star_s[0] : line_s[0];
	assign src_sel[1] = trig_src_r[1] ? star_s[1] : line_s[1];
	assign src_sel[2] = trig_src_r[2] ? line_s[`CTSR_STAR_IO] : line_s[2];

	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_qual
			ctsr_qual u_qual (
				.clk(CLK),
				.rst_n(rst_n),
				.src(src_sel[i]),
				.mode(trig_mode_r[i*`CTSR_MODE_W +: `CTSR_MODE_W]),
				.trig(trig_q[i])
			);
		end
	endgenerate

	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			TRIG_A <= 1'b0;
			TRIG_B <= 1'b0;
			TRIG_C <= 1'b0;
		end else begin
			TRIG_A <= trig_q[0];
			TRIG_B <= trig_q[1];
			TRIG_C <= trig_q[2];
		end
	end

	// Clock switch caught once after reset release, never again
	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			clk_sel_r <= `CTSR_CLK_BACKPLANE;
			clk_sel_done_r <= 1'b0;
		end else if (!clk_sel_done_r) begin
			clk_sel_r <= CLK_SEL_SWITCH;
			clk_sel_done_r <= 1'b1;
		end
	end

	// Register writes
	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			trig_src_r <= 3'h0;
			trig_mode_r <= 6'h00;
			sync_en_r <= 4'h0;
			sw_oe_r <= {NUM_IO{1'b0}};
			sw_val_r <= {NUM_IO{1'b0}};
			stat_sel_r <= `CTSR_STAT_SLOT;
		end else if (WR) begin
			case (ADDR)
				`CTSR_REG_TRIG_SRC: trig_src_r <= WDATA[2:0];
				`CTSR_REG_TRIG_MODE: trig_mode_r <= WDATA[5:0];
				`CTSR_REG_SYNC_EN: sync_en_r <= WDATA[3:0];
				`CTSR_REG_LINE_OE: sw_oe_r <= WDATA[NUM_IO-1:0];
				`CTSR_REG_LINE_VAL: sw_val_r <= WDATA[NUM_IO-1:0];
				`CTSR_REG_STAT_SEL: stat_sel_r <= WDATA[`CTSR_SEL_W-1:0];
				default: trig_src_r <= trig_src_r;
			endcase
		end
	end

	// Core drive arbitration: latest write wins; core B taken when both write at once
	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			drv_oe_r <= {NUM_IO{1'b0}};
			drv_val_r <= {NUM_IO{1'b0}};
		end else if (CORE_B_WR) begin
			drv_oe_r <= CORE_B_OE;
			drv_val_r <= CORE_B_VAL;
		end else if (CORE_A_WR) begin
			drv_oe_r <= CORE_A_OE;
			drv_val_r <= CORE_A_VAL;
		end
	end

	// Sync outputs override the driven value on enabled destinations
	always @* begin
		line_out_nxt = drv_val_r | sw_val_r;
		if (sync_en_r[`CTSR_SYNC_A_LINE0]) begin
			line_out_nxt[0] = SYNC_A;
		end
		if (sync_en_r[`CTSR_SYNC_B_LINE1]) begin
			line_out_nxt[1] = SYNC_B;
		end
		if (sync_en_r[`CTSR_SYNC_C_LINE2]) begin
			line_out_nxt[2] = SYNC_C;
		end
		if (sync_en_r[`CTSR_SYNC_C_STAR]) begin
			line_out_nxt[`CTSR_STAR_IO] = SYNC_C;
		end
	end

	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			LINE_OUT <= {NUM_IO{1'b0}};
			LINE_OE <= {NUM_IO{1'b0}};
		end else begin
			LINE_OUT <= line_out_nxt;
			LINE_OE <= drv_oe_r | sw_oe_r;
		end
	end

	// Mask bit 0 is discrete index 33; indices past the line group read 0
	assign oe_mask = {{(`CTSR_OE_MASK_W-NUM_IO){1'b0}}, LINE_OE};

	always @* begin
		case (stat_sel_r)
			`CTSR_STAT_SLOT: status_nxt = {11'h000, SLOT_ADDR};
			`CTSR_STAT_CLOCK: status_nxt = {15'h0000, clk_sel_r};
			`CTSR_STAT_VERSION: status_nxt = ENGINE_VERSION;
			`CTSR_STAT_OE: status_nxt = oe_mask;
			default: status_nxt = `CTSR_ZERO16;
		endcase
	end

	always @* begin
		case (ADDR)
			`CTSR_REG_TRIG_SRC: rdata_nxt = {13'h0000, trig_src_r};
			`CTSR_REG_TRIG_MODE: rdata_nxt = {10'h000, trig_mode_r};
			`CTSR_REG_SYNC_EN: rdata_nxt = {12'h000, sync_en_r};
			`CTSR_REG_LINE_OE: rdata_nxt = {7'h00, sw_oe_r};
			`CTSR_REG_LINE_VAL: rdata_nxt = {7'h00, sw_val_r};
			`CTSR_REG_STAT_SEL: rdata_nxt = {14'h0000, stat_sel_r};
			`CTSR_REG_STATUS: rdata_nxt = status_nxt;
			`CTSR_REG_TRIG_STATE: rdata_nxt = {13'h0000, TRIG_C, TRIG_B, TRIG_A};
			default: rdata_nxt = `CTSR_ZERO16;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			RDATA <= `CTSR_ZERO16;
			CLOCK_SOURCE <= `CTSR_CLK_BACKPLANE;
			TIMING_DRIVE <= 1'b0;
		end else begin
			RDATA <= RD ? rdata_nxt : `CTSR_ZERO16;
			CLOCK_SOURCE <= clk_sel_r;
			TIMING_DRIVE <= 1'b0;
		end
	end
endmodule // ctsr_router
`default_nettype wire

// ---- testbench/ctsr_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ctsr_map.vh"
module ctsr_monitor #(
	parameter NUM_IO = `CTSR_NUM_IO
) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic [3:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic [NUM_IO-1:0] LINE_IN,
	input wire logic [NUM_IO-1:0] LINE_OUT,
	input wire logic [NUM_IO-1:0] LINE_OE,
	input wire logic STAR_A_IN,
	input wire logic SYNC_A,
	input wire logic SYNC_C,
	input wire logic TRIG_A,
	input wire logic CLOCK_SOURCE,
	input wire logic TIMING_DRIVE
);
	// Bus mirror of the settings that decide trigger A and the sync routes
	logic [3:0] sen_r;
	logic [1:0] mode_r;
	logic src_a_r;
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			sen_r <= 4'h0;
			mode_r <= 2'h0;
			src_a_r <= 1'b0;
		end else if (WR) begin
			if (ADDR == `CTSR_REG_SYNC_EN) sen_r <= WDATA[3:0];
			if (ADDR == `CTSR_REG_TRIG_MODE) mode_r <= WDATA[1:0];
			if (ADDR == `CTSR_REG_TRIG_SRC) src_a_r <= WDATA[0];
		end
	end
	wire hs = mode_r == `CTSR_MODE_HIGH && src_a_r == `CTSR_SRC_STAR;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	a_sync_a_route: assert property (sen_r[0] && $past(sen_r[0]) |->
		LINE_OUT[0] == $past(SYNC_A)) else $error("sync A missing on line 0");
	a_sync_c_both: assert property (sen_r[3:2] == 2'h3 && $past(sen_r[3:2]) == 2'h3 |->
		LINE_OUT[2] == $past(SYNC_C) && LINE_OUT[`CTSR_STAR_IO] == $past(SYNC_C))
		else $error("sync C not on both lines");
	a_level_hold: assert property ((hs && STAR_A_IN) [*8] |-> TRIG_A)
		else $error("level trigger dropped");
	a_src_excl: assert property ((hs && !STAR_A_IN && LINE_IN[0]) [*8] |-> !TRIG_A)
		else $error("unselected source fired");
	a_sync_first: assert property (hs && $rose(TRIG_A) |-> $past(STAR_A_IN, 3))
		else $error("trigger ahead of synchroniser");
	a_edge_pulse: assert property (mode_r[1] && $stable(mode_r) && TRIG_A |=> !TRIG_A)
		else $error("edge trigger longer than one cycle");
	a_timing_never: assert property (!TIMING_DRIVE)
		else $error("timing function driven");
	a_clk_held: assert property (!$fell(CLOCK_SOURCE))
		else $error("clock selection changed");
	a_tristate_up: assert property ($rose(RESETN) |-> (LINE_OE == '0) [*3])
		else $error("line driven after reset");
	cover property (TRIG_A && mode_r[1]);
	cover property (sen_r[3:2] == 2'h3 && SYNC_C);
	cover property ($rose(CLOCK_SOURCE));
endmodule // ctsr_monitor
bind ctsr_router ctsr_monitor #(.NUM_IO(NUM_IO)) mon (.CLK(CLK), .RESETN(RESETN),
	.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .LINE_IN(LINE_IN), .LINE_OUT(LINE_OUT),
	.LINE_OE(LINE_OE), .STAR_A_IN(STAR_A_IN), .SYNC_A(SYNC_A), .SYNC_C(SYNC_C),
	.TRIG_A(TRIG_A), .CLOCK_SOURCE(CLOCK_SOURCE), .TIMING_DRIVE(TIMING_DRIVE));
`default_nettype wire

// ---- testbench/ctsr_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module ctsr_partner (
	input wire logic lvl,
	input wire logic [8:0] line_out,
	input wire logic [8:0] line_oe,
	output wire logic [8:0] line_in,
	output wire logic star_a,
	output wire logic star_b
);
	// Unselected sources move opposite, so a wrong pick shows; idle lines pulled up
	wire [8:0] far = {lvl, 5'h1F, ~lvl, lvl, ~lvl};
	assign line_in = (line_oe & line_out) | (~line_oe & far);
	assign star_a = lvl;
	assign star_b = ~lvl;
endmodule // ctsr_partner
`default_nettype wire

// ---- testbench/chassis_trigger_sync_router_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ctsr_map.vh"
module chassis_trigger_sync_router_test;
	localparam logic [15:0] VER = 16'h005A; // Arbitrary value
	logic CLK = 0, RESETN = 0, WR = 0, RD = 0, v = 0, CLK_SEL_SWITCH = 1;
	logic SYNC_A = 0, SYNC_B = 0, SYNC_C = 0, CORE_A_WR = 0, CORE_B_WR = 0;
	logic [3:0] ADDR = 0;
	logic [15:0] WDATA = 0;
	logic [4:0] SLOT_ADDR = 5'h0B;
	logic [8:0] CORE_A_OE = 0, CORE_B_OE = 0, CORE_A_VAL = 0, CORE_B_VAL = 0;
	wire [15:0] RDATA;
	wire [8:0] LINE_IN, LINE_OUT, LINE_OE;
	wire STAR_A_IN, STAR_B_IN, TRIG_A, TRIG_B, TRIG_C, CLOCK_SOURCE, TIMING_DRIVE;
	int err_total = 0, cmp_count = 0;
	initial forever #5 CLK = ~CLK;
	ctsr_router #(.ENGINE_VERSION(VER), .NUM_IO(9)) dut (.CLK(CLK), .RESETN(RESETN),
		.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .LINE_IN(LINE_IN),
		.LINE_OUT(LINE_OUT), .LINE_OE(LINE_OE), .STAR_A_IN(STAR_A_IN), .STAR_B_IN(STAR_B_IN),
		.SLOT_ADDR(SLOT_ADDR), .CLK_SEL_SWITCH(CLK_SEL_SWITCH), .SYNC_A(SYNC_A),
		.SYNC_B(SYNC_B), .SYNC_C(SYNC_C), .CORE_A_WR(CORE_A_WR), .CORE_B_WR(CORE_B_WR),
		.CORE_A_OE(CORE_A_OE), .CORE_B_OE(CORE_B_OE), .CORE_A_VAL(CORE_A_VAL),
		.CORE_B_VAL(CORE_B_VAL), .TRIG_A(TRIG_A), .TRIG_B(TRIG_B), .TRIG_C(TRIG_C),
		.CLOCK_SOURCE(CLOCK_SOURCE), .TIMING_DRIVE(TIMING_DRIVE));
	ctsr_partner far_end (.lvl(v), .line_out(LINE_OUT), .line_oe(LINE_OE),
		.line_in(LINE_IN), .star_a(STAR_A_IN), .star_b(STAR_B_IN));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge CLK);
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1;
		@(posedge CLK);
		WR <= 0;
	endtask
	task rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1;
		@(posedge CLK);
		RD <= 0;
		#1 chk(RDATA, exp);
		@(posedge CLK);
		#1 chk(RDATA, 16'h0000);
	endtask
	task core(input logic b, input logic [8:0] oe, input logic [8:0] val);
		@(posedge CLK);
		if (b) begin
			CORE_B_OE <= oe;
			CORE_B_VAL <= val;
			CORE_B_WR <= 1;
		end else begin
			CORE_A_OE <= oe;
			CORE_A_VAL <= val;
			CORE_A_WR <= 1;
		end
		@(posedge CLK);
		CORE_A_WR <= 0;
		CORE_B_WR <= 0;
	endtask
	task t_status;
		wr(`CTSR_REG_LINE_OE, 16'h0005);
		wr(`CTSR_REG_STAT_SEL, 16'h0000);
		rd(`CTSR_REG_STATUS, 16'h000B);
		wr(`CTSR_REG_STAT_SEL, 16'h0001);
		rd(`CTSR_REG_STATUS, 16'h0001);
		CLK_SEL_SWITCH <= 0;
		rd(`CTSR_REG_STATUS, 16'h0001);
		chk({15'h0, CLOCK_SOURCE}, 16'h0001);
		chk({15'h0, TIMING_DRIVE}, 16'h0000);
		wr(`CTSR_REG_STAT_SEL, 16'h0002);
		rd(`CTSR_REG_STATUS, VER);
		wr(`CTSR_REG_STAT_SEL, 16'h0003);
		rd(`CTSR_REG_STATUS, 16'h0005);
		chk({7'h0, LINE_OE}, 16'h0005);
		rd(`CTSR_REG_TRIG_SRC, 16'h0000);
		rd(4'hF, 16'h0000);
		wr(`CTSR_REG_LINE_OE, 16'h0000);
		$display("t_status done");
	endtask
	task t_sync;
		wr(`CTSR_REG_SYNC_EN, 16'h000F);
		SYNC_A <= 1;
		SYNC_B <= 1;
		SYNC_C <= 1;
		cyc(3);
		#1 chk({7'h0, LINE_OUT} & 16'h0107, 16'h0107);
		wr(`CTSR_REG_SYNC_EN, 16'h0000);
		SYNC_A <= 0;
		SYNC_B <= 0;
		SYNC_C <= 0;
		$display("t_sync done");
	endtask
	task t_core;
		core(0, 9'h008, 9'h008);
		core(1, 9'h008, 9'h000);
		cyc(3);
		#1 chk({14'h0, LINE_OE[3], LINE_OUT[3]}, 16'h0002);
		core(0, 9'h008, 9'h008);
		cyc(3);
		#1 chk({14'h0, LINE_OE[3], LINE_OUT[3]}, 16'h0003);
		core(0, 9'h000, 9'h000);
		core(1, 9'h000, 9'h000);
		$display("t_core done");
	endtask
	// Counts trigger rises and the level left after one source change
	task watch(input logic [1:0] ex);
		int c [3];
		logic [2:0] p;
		int j;
		c = '{0, 0, 0};
		p = {TRIG_C, TRIG_B, TRIG_A};
		repeat (20) begin
			@(posedge CLK);
			#1;
			for (j = 0; j < 3; j++) if ({TRIG_C, TRIG_B, TRIG_A} >> j & ~p >> j & 1) c[j]++;
			p = {TRIG_C, TRIG_B, TRIG_A};
		end
		for (j = 0; j < 3; j++) chk({c[j][7:0], 7'h0, p[j]}, {7'h0, ex[1], 7'h0, ex[0]});
	endtask
	task t_trig;
		logic [15:0] tab;
		logic [1:0] m;
		int k;
		tab = 16'h283C;
		wr(`CTSR_REG_TRIG_SRC, 16'h0005);
		rd(`CTSR_REG_TRIG_SRC, 16'h0005);
		for (k = 0; k < 4; k++) begin
			m = k[1:0] ^ 2'h2;
			wr(`CTSR_REG_TRIG_MODE, {10'h0, m, m, m});
			cyc(10);
			v <= 1;
			watch(tab[m*4+2 +: 2]);
			v <= 0;
			watch(tab[m*4 +: 2]);
		end
		$display("t_trig done");
	endtask
	task give_verdict;
		$display("Checks %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#50000;
		err_total++;
		give_verdict;
	end
	initial begin
		cyc(4);
		RESETN <= 1;
		cyc(4);
		t_status;
		t_sync;
		t_core;
		t_trig;
		give_verdict;
	end
endmodule // chassis_trigger_sync_router_test
`default_nettype wire
